// ==== pkg/door_safety_pkg.sv ====
// Constants, types and register map of the door safety sensor response block
package door_safety_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int TEST_PERIOD_US = 1000;
  localparam int TEST_LOW_US = 10;
  localparam int TEST_PERIOD_CYCLES = TEST_PERIOD_US * CLK_MHZ;
  localparam int TEST_LOW_CYCLES = TEST_LOW_US * CLK_MHZ;
  localparam int TEST_SETTLE_CYCLES = 4;
  localparam int TEST_CNT_W = 18;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RANGE = 8'h04;
  localparam logic [7:0] ADDR_LIMIT = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] RANGE_RESET = 32'hFFFF_FFFF;
  localparam logic [31:0] LIMIT_RESET = 32'hFFFF_FFFF;
  localparam int CTRL_TYPE_LSB = 0;
  localparam int CTRL_ORDER_LSB = 2;
  localparam int STAT_TORQUE = 0;
  localparam int STAT_SPEED = 1;
  localparam int STAT_SENSOR = 2;
  localparam int STAT_BLOCK = 3;
  localparam int STAT_STATE_LSB = 8;
  localparam int STAT_LEVEL = 16;
  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SENSOR_DYN = 2'h0;
  localparam logic [1:0] SENSOR_CURTAIN = 2'h1;
  localparam logic [1:0] SENSOR_EDGE = 2'h2;
  localparam logic [1:0] ORDER_RAMP = 2'h0;
  localparam logic [1:0] ORDER_STOP_DEEN = 2'h1;
  localparam logic [1:0] ORDER_DEEN = 2'h2;
  localparam logic [1:0] ORDER_CONTINUE = 2'h3;
  localparam logic [3:0] CMD_STOP_BLOCK = 4'h8;
  // Door position in millimetres, zero at the closed position
  localparam int POS_MM_PER_CM = 10;
  localparam int EDGE_REVERSE_CM = 20;
  localparam int OPEN_BAND_CM = 2;
  localparam logic [15:0] EDGE_REVERSE_MM = 16'(EDGE_REVERSE_CM * POS_MM_PER_CM);
  localparam logic [16:0] OPEN_BAND_MM = 17'(OPEN_BAND_CM * POS_MM_PER_CM);
  typedef enum logic [1:0] {
    MODE_LEARN = 2'h0,
    MODE_INITIAL = 2'h1,
    MODE_NORMAL = 2'h2,
    MODE_SPECIAL = 2'h3
  } sys_mode_t;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_RAMP = 7'h02,
    ST_STOP_DEEN = 7'h04,
    ST_DEEN = 7'h08,
    ST_REV_CURTAIN = 7'h10,
    ST_REV_EDGE = 7'h20,
    ST_ERROR = 7'h40
  } react_state_t;
endpackage

// ==== src/door_safety_sensor_response.sv ====
// Safety sensor reaction, test pulse supervision, command blocking and APB registers
//
// Contract
// - Light curtain input high is clear, low is interrupted; reaction depends on mode.
// - In learn run, curtain or edge trip cancels learning and de-energizes drive.
// - Initial and special mode: curtain trip during close order ramps to stop.
// - Normal mode: curtain trip during close order reverses the door.
// - Order after obstruction while curtain reversing is chosen by a parameter.
// - Positioning: curtain trip ramps to stop; edge trip ramps, then de-energizes.
// - Edge input high is clear and healthy, low is interrupted or defective.
// - Initial mode: edge trip during any order ramps to stop then de-energizes.
// - Normal mode: edge trip during any order reverses the door twenty centimetres.
// - Obstruction during edge reversal stops the drive and then de-energizes it.
// - With input one set to edge, the test output is driven automatically.
// - Input one sensor function is chosen by a configuration parameter.
// - Edge reactions are limited to a configurable range before closed position.
// - Edge signal is ignored within two centimetres before the open position.
// - Only one sensor function may be assigned to input one at once.
// - Command value eight stops and blocks all further door commands, service too.
// - Torque above configured maximum is detected and gives an error response.
// - Speed above configured maximum is detected and gives an error response.
// - Test pulse detects an edge input stuck high; an open or low input reads as a trip.
// - Outside normal operation, sensor signals are forced to their resting values.
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module door_safety_sensor_response #(
  parameter int TEST_PERIOD = door_safety_pkg::TEST_PERIOD_CYCLES
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sensorPin,
  input wire logic opState,
  input wire door_safety_pkg::sys_mode_t systemMode,
  input wire logic positioning,
  input wire logic closeOrder,
  input wire logic openOrder,
  input wire logic obstruction,
  input wire logic standstill,
  input wire logic [15:0] doorPos,
  input wire logic [15:0] torque,
  input wire logic [15:0] speed,
  input wire logic [3:0] cmdIn,
  input wire logic cmdInValid,
  input wire logic [3:0] serviceCmd,
  input wire logic serviceCmdValid,
  output logic [3:0] cmdOut,
  output logic cmdOutValid,
  output logic cmdBlocked,
  output logic sensorTestOut,
  output logic rampStop,
  output logic deenergize,
  output logic reverseOrder,
  output logic learnCancel,
  output logic errorResponse
);
  import door_safety_pkg::*;

  // ----------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------
  logic pinSync1;
  logic pinSync2;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pinSync1 <= 1'b1;
      pinSync2 <= 1'b1;
    end else begin
      pinSync1 <= sensorPin;
      pinSync2 <= pinSync1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] ctrlReg;
  logic [31:0] rangeReg;
  logic [31:0] limitReg;
  logic torqueFault;
  logic speedFault;
  logic sensorFault;
  logic [31:0] next_ctrlReg;
  logic [31:0] next_rangeReg;
  logic [31:0] next_limitReg;
  logic next_torqueFault;
  logic next_speedFault;
  logic next_sensorFault;
  logic next_cmdBlocked;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [1:0] sensorType;
  logic [1:0] revObstOrder;
  logic [15:0] reactionRange;
  logic [15:0] openPos;
  logic [15:0] maxTorque;
  logic [15:0] maxSpeed;
  logic setupPhase;
  logic wrStrobe;
  logic torqueOver;
  logic speedOver;
  logic testFail;
  logic blockSet;
  react_state_t state;

  assign sensorType = ctrlReg[CTRL_TYPE_LSB +: 2];
  assign revObstOrder = ctrlReg[CTRL_ORDER_LSB +: 2];
  assign reactionRange = rangeReg[15:0];
  assign openPos = rangeReg[31:16];
  assign maxTorque = limitReg[15:0];
  assign maxSpeed = limitReg[31:16];
  assign setupPhase = psel && !penable;
  assign wrStrobe = psel && penable && pwrite && pready;
  assign torqueOver = torque > maxTorque;
  assign speedOver = speed > maxSpeed;
  assign blockSet = (cmdInValid && cmdIn == CMD_STOP_BLOCK) ||
                    (serviceCmdValid && serviceCmd == CMD_STOP_BLOCK);

  always_comb begin
    next_ctrlReg = ctrlReg;
    next_rangeReg = rangeReg;
    next_limitReg = limitReg;
    next_torqueFault = torqueFault;
    next_speedFault = speedFault;
    next_sensorFault = sensorFault;
    next_cmdBlocked = cmdBlocked;
    next_prdata = prdata;
    next_pready = setupPhase;
    next_pslverr = 1'b0;
    if (setupPhase) begin
      next_pslverr = !(paddr == ADDR_CTRL || paddr == ADDR_RANGE ||
                       paddr == ADDR_LIMIT || paddr == ADDR_STATUS);
      unique case (paddr)
        ADDR_CTRL: next_prdata = {28'h0000000, ctrlReg[3:0]};
        ADDR_RANGE: next_prdata = rangeReg;
        ADDR_LIMIT: next_prdata = limitReg;
        ADDR_STATUS: begin
          next_prdata = 32'h0000_0000;
          next_prdata[STAT_TORQUE] = torqueFault;
          next_prdata[STAT_SPEED] = speedFault;
          next_prdata[STAT_SENSOR] = sensorFault;
          next_prdata[STAT_BLOCK] = cmdBlocked;
          next_prdata[STAT_STATE_LSB +: 7] = state;
          next_prdata[STAT_LEVEL] = pinSync2;
        end
        default: next_prdata = 32'h0000_0000;
      endcase
    end
    if (wrStrobe) begin
      unique case (paddr)
        ADDR_CTRL: next_ctrlReg = {28'h0000000, pwdata[3:0]};
        ADDR_RANGE: next_rangeReg = pwdata;
        ADDR_LIMIT: next_limitReg = pwdata;
        ADDR_STATUS: begin
          if (pwdata[STAT_TORQUE]) next_torqueFault = 1'b0;
          if (pwdata[STAT_SPEED]) next_speedFault = 1'b0;
          if (pwdata[STAT_SENSOR]) next_sensorFault = 1'b0;
          if (pwdata[STAT_BLOCK]) next_cmdBlocked = 1'b0;
        end
        default: next_ctrlReg = ctrlReg;
      endcase
    end
    // Events win over a clear in the same cycle
    if (torqueOver) next_torqueFault = 1'b1;
    if (speedOver) next_speedFault = 1'b1;
    if (testFail) next_sensorFault = 1'b1;
    if (blockSet) next_cmdBlocked = 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctrlReg <= CTRL_RESET;
      rangeReg <= RANGE_RESET;
      limitReg <= LIMIT_RESET;
      torqueFault <= 1'b0;
      speedFault <= 1'b0;
      sensorFault <= 1'b0;
      cmdBlocked <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrlReg <= next_ctrlReg;
      rangeReg <= next_rangeReg;
      limitReg <= next_limitReg;
      torqueFault <= next_torqueFault;
      speedFault <= next_speedFault;
      sensorFault <= next_sensorFault;
      cmdBlocked <= next_cmdBlocked;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // Sensor test pulse and trip qualification
  // ----------------------------------------------------------------
  logic [TEST_CNT_W-1:0] testCnt;
  logic [TEST_CNT_W-1:0] next_testCnt;
  logic next_sensorTestOut;
  logic testMask;
  logic sensorLevel;
  logic curtainTrip;
  logic edgeTrip;
  logic edgeOpenBand;
  logic edgeInRange;
  logic edgeSel;

  assign edgeSel = sensorType == SENSOR_EDGE;
  assign testMask = edgeSel &&
    (testCnt >= TEST_CNT_W'(TEST_PERIOD - TEST_LOW_CYCLES) ||
     testCnt < TEST_CNT_W'(TEST_SETTLE_CYCLES));
  assign testFail = edgeSel && opState && pinSync2 &&
    testCnt == TEST_CNT_W'(TEST_PERIOD - 1);
  // Resting level outside operation and during test pulses
  assign sensorLevel = (opState && !testMask) ? pinSync2 : 1'b1;
  assign edgeOpenBand = ({1'b0, doorPos} + OPEN_BAND_MM) >= {1'b0, openPos};
  assign edgeInRange = doorPos <= reactionRange;
  assign curtainTrip = sensorType == SENSOR_CURTAIN && !sensorLevel;
  // A defective edge acts like a tripped one
  assign edgeTrip = edgeSel && (!sensorLevel || sensorFault) &&
                    edgeInRange && !edgeOpenBand;

  always_comb begin
    next_testCnt = '0;
    next_sensorTestOut = 1'b1;
    if (edgeSel) begin
      next_testCnt = (testCnt == TEST_CNT_W'(TEST_PERIOD - 1)) ? '0 : testCnt + 1'b1;
      next_sensorTestOut =
        next_testCnt < TEST_CNT_W'(TEST_PERIOD - TEST_LOW_CYCLES);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      testCnt <= '0;
      sensorTestOut <= 1'b1;
    end else begin
      testCnt <= next_testCnt;
      sensorTestOut <= next_sensorTestOut;
    end
  end

  // ----------------------------------------------------------------
  // Door command gate
  // ----------------------------------------------------------------
  logic [3:0] next_cmdOut;
  logic next_cmdOutValid;

  always_comb begin
    next_cmdOut = cmdOut;
    next_cmdOutValid = 1'b0;
    if (!cmdBlocked) begin
      if (cmdInValid) begin
        next_cmdOut = cmdIn;
        next_cmdOutValid = 1'b1;
      end else if (serviceCmdValid) begin
        next_cmdOut = serviceCmd;
        next_cmdOutValid = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cmdOut <= 4'h0;
      cmdOutValid <= 1'b0;
    end else begin
      cmdOut <= next_cmdOut;
      cmdOutValid <= next_cmdOutValid;
    end
  end

  // ----------------------------------------------------------------
  // Reaction state machine
  // ----------------------------------------------------------------
  react_state_t next_state;
  logic [15:0] revStart;
  logic [15:0] next_revStart;
  logic [15:0] revTravel;
  logic anyOrder;
  logic overload;

  assign anyOrder = closeOrder || openOrder;
  assign overload = torqueOver || speedOver || torqueFault || speedFault;
  assign revTravel = (doorPos >= revStart) ? doorPos - revStart : revStart - doorPos;

  always_comb begin
    next_state = state;
    next_revStart = revStart;
    if (overload) begin
      next_state = ST_ERROR;
    end else begin
      unique case (state)
        ST_IDLE: begin
          unique case (systemMode)
            MODE_LEARN: if (curtainTrip || edgeTrip) next_state = ST_DEEN;
            MODE_INITIAL: begin
              if (edgeTrip && anyOrder) next_state = ST_STOP_DEEN;
              else if (curtainTrip && closeOrder) next_state = ST_RAMP;
            end
            MODE_NORMAL: begin
              if (positioning) begin
                if (edgeTrip) next_state = ST_STOP_DEEN;
                else if (curtainTrip) next_state = ST_RAMP;
              end else if (edgeTrip && anyOrder) begin
                next_state = ST_REV_EDGE;
                next_revStart = doorPos;
              end else if (curtainTrip && closeOrder) begin
                next_state = ST_REV_CURTAIN;
              end
            end
            MODE_SPECIAL: if (curtainTrip && closeOrder) next_state = ST_RAMP;
          endcase
        end
        ST_RAMP: if (standstill && sensorLevel) next_state = ST_IDLE;
        ST_STOP_DEEN: if (standstill) next_state = ST_DEEN;
        ST_DEEN: if (!anyOrder) next_state = ST_IDLE;
        ST_REV_CURTAIN: begin
          if (obstruction) begin
            unique case (revObstOrder)
              ORDER_RAMP: next_state = ST_RAMP;
              ORDER_STOP_DEEN: next_state = ST_STOP_DEEN;
              ORDER_DEEN: next_state = ST_DEEN;
              ORDER_CONTINUE: next_state = ST_IDLE;
            endcase
          end else if (!closeOrder) begin
            next_state = ST_IDLE;
          end
        end
        ST_REV_EDGE: begin
          if (obstruction) next_state = ST_STOP_DEEN;
          else if (revTravel >= EDGE_REVERSE_MM) next_state = ST_RAMP;
        end
        ST_ERROR: next_state = ST_DEEN;
        default: next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state <= ST_IDLE;
      revStart <= 16'h0000;
      rampStop <= 1'b0;
      deenergize <= 1'b0;
      reverseOrder <= 1'b0;
      learnCancel <= 1'b0;
      errorResponse <= 1'b0;
    end else begin
      state <= next_state;
      revStart <= next_revStart;
      rampStop <= next_state == ST_RAMP || next_state == ST_STOP_DEEN;
      deenergize <= next_state == ST_DEEN || next_state == ST_ERROR;
      reverseOrder <= next_state == ST_REV_CURTAIN || next_state == ST_REV_EDGE;
      learnCancel <= next_state == ST_DEEN && systemMode == MODE_LEARN;
      errorResponse <= next_state == ST_ERROR;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence s_idle_ok;
    state == ST_IDLE && !overload;
  endsequence
  sequence s_stop_then_deen;
    state == ST_STOP_DEEN && rampStop;
  endsequence

  property p_learn_cancel;
    s_idle_ok and systemMode == MODE_LEARN && (curtainTrip || edgeTrip)
      |=> deenergize && learnCancel;
  endproperty
  a_learn_cancel: assert property (p_learn_cancel) else $error("learn not cancelled");
  property p_curtain_stop;
    s_idle_ok and systemMode == MODE_INITIAL && curtainTrip && closeOrder && !edgeTrip
      |=> rampStop && !reverseOrder;
  endproperty
  a_curtain_stop: assert property (p_curtain_stop) else $error("no ramp stop");
  property p_curtain_reverse;
    s_idle_ok and systemMode == MODE_NORMAL && !positioning && curtainTrip &&
      closeOrder && !edgeTrip |=> reverseOrder && state == ST_REV_CURTAIN;
  endproperty
  a_curtain_reverse: assert property (p_curtain_reverse) else $error("no reversal");
  property p_rev_obstruct;
    state == ST_REV_CURTAIN && obstruction && !overload &&
      revObstOrder == ORDER_STOP_DEEN |=> s_stop_then_deen;
  endproperty
  a_rev_obstruct: assert property (p_rev_obstruct) else $error("bad order");
  property p_edge_obstruct;
    state == ST_REV_EDGE && obstruction && !overload |=> s_stop_then_deen;
  endproperty
  a_edge_obstruct: assert property (p_edge_obstruct) else $error("edge stop missing");
  property p_edge_distance;
    state == ST_REV_EDGE && !obstruction && !overload && revTravel >= EDGE_REVERSE_MM
      |=> state == ST_RAMP && !reverseOrder;
  endproperty
  a_edge_distance: assert property (p_edge_distance) else $error("reversal long");
  property p_open_band;
    edgeOpenBand |-> !edgeTrip;
  endproperty
  a_open_band: assert property (p_open_band) else $error("edge in open band");
  property p_rest;
    !opState |-> !curtainTrip && (edgeTrip == (edgeSel && sensorFault &&
      edgeInRange && !edgeOpenBand));
  endproperty
  a_rest: assert property (p_rest) else $error("sensor not at rest");
  property p_sync;
    $past(nrst, 2) |-> pinSync2 == $past(sensorPin, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("sync depth wrong");
  property p_block;
    blockSet |=> cmdBlocked ##1 !cmdOutValid;
  endproperty
  a_block: assert property (p_block) else $error("commands not blocked");
  property p_torque;
    torqueOver |=> errorResponse && deenergize && torqueFault;
  endproperty
  a_torque: assert property (p_torque) else $error("torque not caught");
  property p_speed;
    speedOver |=> errorResponse && speedFault;
  endproperty
  a_speed: assert property (p_speed) else $error("speed not caught");
  property p_test_fail;
    testFail |=> sensorFault;
  endproperty
  a_test_fail: assert property (p_test_fail) else $error("stuck edge missed");
  property p_test_out;
    !edgeSel && $past(!edgeSel) |-> sensorTestOut;
  endproperty
  a_test_out: assert property (p_test_out) else $error("test output active");
endmodule
`default_nettype wire

// ==== bench/door_partner.sv ====
// Sensor and motor drive stage model on the far side of the block
`timescale 1ns/100ps
`default_nettype none
module door_partner (
  input wire logic sys_clk,
  input wire logic rampStop,
  input wire logic sensor_test_output,
  input wire logic trip,
  input wire logic stuck,
  output logic sensorPin,
  output logic standstill
);
  logic [2:0] cnt = 3'h0;
  // Sensor follows the test pulse, low while pressed
  assign sensorPin = (sensor_test_output | stuck) & ~trip;
  // Drive comes to rest a few cycles into a ramp
  assign standstill = &cnt;
  always_ff @(posedge sys_clk) begin
    cnt <= rampStop ? cnt + 3'(cnt != 3'h7) : 3'h0;
  end
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking testbench of the door safety sensor response block
`timescale 1ns/100ps
`default_nettype none
module tb;
  import door_safety_pkg::*;
  localparam int TP = 4100;
  logic sys_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdData;
  logic pready, pslverr, rdErr, sensorPin, standstill, trip = 1'b0, opState = 1'b1;
  sys_mode_t systemMode = MODE_NORMAL;
  logic closeOrder = 1'b0, openOrder = 1'b0, cmdInValid = 1'b0, serviceCmdValid = 1'b0;
  logic [15:0] doorPos = 16'h0064, torque = 16'h0000, speed = 16'h0000;
  logic [3:0] cmdIn = 4'h0, serviceCmd = 4'h0, cmdOut;
  logic cmdOutValid, cmdBlocked, sensorTestOut, rampStop, deenergize;
  logic reverseOrder, learnCancel, errorResponse;
  logic positioning = 1'b0, obstruction = 1'b0, stuck = 1'b0;
  int errCount = 0, totalChecks = 0;

  door_safety_sensor_response #(.TEST_PERIOD(TP)) i_door_safety_sensor_response (
    .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sensorPin(sensorPin), .opState(opState), .systemMode(systemMode),
    .positioning(positioning), .closeOrder(closeOrder), .openOrder(openOrder),
    .obstruction(obstruction), .standstill(standstill), .doorPos(doorPos), .torque(torque),
    .speed(speed), .cmdIn(cmdIn), .cmdInValid(cmdInValid), .serviceCmd(serviceCmd),
    .serviceCmdValid(serviceCmdValid), .cmdOut(cmdOut), .cmdOutValid(cmdOutValid),
    .cmdBlocked(cmdBlocked), .sensorTestOut(sensorTestOut), .rampStop(rampStop),
    .deenergize(deenergize), .reverseOrder(reverseOrder), .learnCancel(learnCancel),
    .errorResponse(errorResponse));

  door_partner i_door_partner (.sys_clk(sys_clk), .rampStop(rampStop),
    .sensor_test_output(sensorTestOut), .trip(trip), .stuck(stuck), .sensorPin(sensorPin),
    .standstill(standstill));

  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic summarize;
    if (errCount == 0 && totalChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      errCount++;
      summarize();
    end
    @(posedge sys_clk);
  endtask

  task automatic doReset;
    nrst <= 1'b0;
    trip <= 1'b0;
    closeOrder <= 1'b0;
    positioning <= 1'b0;
    obstruction <= 1'b0;
    stuck <= 1'b0;
    opState <= 1'b1;
    torque <= 16'h0000;
    speed <= 16'h0000;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic scnRegs;
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rdData, CTRL_RESET);
    apb(1'b0, ADDR_RANGE, 32'h0);
    check(rdData, RANGE_RESET);
    apb(1'b1, ADDR_CTRL, 32'hFFFF_FFF6);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rdData, 32'h0000_0006);
    apb(1'b0, 8'h10, 32'h0);
    check(32'(rdErr), 32'h1);
    check(rdData, 32'h0);
  endtask

  task automatic scnCurtain(input sys_mode_t m, input logic op, input logic p);
    logic [2:0] exp;
    doReset();
    apb(1'b1, ADDR_CTRL, 32'(SENSOR_CURTAIN));
    exp = (m == MODE_LEARN) ? 3'h4 : (m == MODE_NORMAL && !p) ? 3'h1 : 3'h2;
    systemMode <= m;
    positioning <= p;
    opState <= op;
    closeOrder <= 1'b1;
    trip <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check(32'({learnCancel, rampStop, reverseOrder}), 32'(op ? exp : 3'h0));
  endtask

  task automatic scnEdge(input logic [15:0] pos, input logic [31:0] rng, input logic expRev);
    doReset();
    apb(1'b1, ADDR_CTRL, 32'(SENSOR_EDGE));
    apb(1'b1, ADDR_RANGE, rng);
    systemMode <= MODE_NORMAL;
    doorPos <= pos;
    closeOrder <= 1'b1;
    trip <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check(32'(reverseOrder), 32'(expRev));
  endtask

  task automatic scnPulse(input logic stk);
    int n;
    doReset();
    apb(1'b1, ADDR_CTRL, 32'(SENSOR_EDGE));
    stuck <= stk;
    for (n = 0; n < TP && sensorTestOut !== 1'b0; n++) @(posedge sys_clk);
    check(32'(sensorTestOut), 32'h0);
    for (n = 0; n < TP && sensorTestOut !== 1'b1; n++) @(posedge sys_clk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(32'({sensorTestOut, rdData[STAT_SENSOR]}), 32'({1'b1, stk}));
  endtask

  task automatic scnRevObst(input logic edgeType);
    doReset();
    apb(1'b1, ADDR_CTRL, edgeType ? 32'(SENSOR_EDGE) :
        32'({ORDER_STOP_DEEN, SENSOR_CURTAIN}));
    systemMode <= MODE_NORMAL;
    closeOrder <= 1'b1;
    trip <= 1'b1;
    repeat (6) @(posedge sys_clk);
    check(32'(reverseOrder), 32'h1);
    obstruction <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check(32'({rampStop, reverseOrder, deenergize}), 32'h4);
    repeat (10) @(posedge sys_clk);
    check(32'({rampStop, deenergize}), 32'h1);
  endtask

  task automatic scnCmd;
    doReset();
    cmdIn <= CMD_STOP_BLOCK;
    cmdInValid <= 1'b1;
    serviceCmd <= 4'h3;
    serviceCmdValid <= 1'b1;
    @(posedge sys_clk);
    cmdInValid <= 1'b0;
    @(posedge sys_clk);
    check(32'({cmdOutValid, cmdOut}), 32'h18);
    serviceCmdValid <= 1'b0;
    @(posedge sys_clk);
    check(32'({cmdOutValid, cmdBlocked}), 32'h1);
    apb(1'b1, ADDR_STATUS, 32'h0000_0008);
    serviceCmdValid <= 1'b1;
    @(posedge sys_clk);
    serviceCmdValid <= 1'b0;
    @(posedge sys_clk);
    check(32'({cmdOutValid, cmdOut}), 32'h13);
  endtask

  task automatic scnOver(input logic spd);
    int n;
    doReset();
    apb(1'b1, ADDR_LIMIT, 32'h0100_0100);
    torque <= spd ? 16'h0000 : 16'h0101;
    speed <= spd ? 16'h0101 : 16'h0000;
    for (n = 0; n < 8 && errorResponse !== 1'b1; n++) @(posedge sys_clk);
    check(32'({errorResponse, deenergize}), 32'h3);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(32'(rdData[1:0]), spd ? 32'h2 : 32'h1);
  endtask

  initial begin
    doReset();
    scnRegs();
    scnCurtain(MODE_LEARN, 1'b1, 1'b0);
    scnCurtain(MODE_INITIAL, 1'b1, 1'b0);
    scnCurtain(MODE_NORMAL, 1'b1, 1'b0);
    scnCurtain(MODE_SPECIAL, 1'b1, 1'b0);
    scnCurtain(MODE_NORMAL, 1'b0, 1'b0);
    scnCurtain(MODE_NORMAL, 1'b1, 1'b1);
    scnEdge(16'h0064, 32'h03E8_01F4, 1'b1);
    scnEdge(16'h03DE, 32'h03E8_03E8, 1'b0);
    scnEdge(16'h0258, 32'h03E8_01F4, 1'b0);
    scnPulse(1'b0);
    scnPulse(1'b1);
    scnRevObst(1'b0);
    scnRevObst(1'b1);
    scnCmd();
    scnOver(1'b0);
    scnOver(1'b1);
    summarize();
  end
endmodule
`default_nettype wire
